// >>> include/scrpo_pkg.sv
// Constants, types and register map of the speed follow block
//
// Functional notes
// RULE1: Source first input alone: count it, pulse on first output, neighbour stays ordinary.
// RULE2: Source second input: first/second inputs are A/B, outputs are pulse/direction.
// RULE3: Source third input alone: count it, pulse on third output, fourth stays ordinary.
// RULE4: Source fourth input: third/fourth inputs are A/B, outputs are pulse/direction.
// RULE5: Refuse start when chosen input pair or output pair is claimed elsewhere.
// RULE6: Two-phase input is always decoded at four counts per quadrature cycle.
// RULE7: Output pulse count copied to its registers only when the instruction executes.
// RULE8: Sample block word one is pulses per speed sample; one samples every pulse.
// RULE9: Sample count clamped to 1..100 single phase, 2..100 two phase.
// RULE10: New sample count takes effect only at the next instruction execution.
// RULE11: Latest sampled speed reads back as signed 1 Hz word, range +-10 kHz.
// RULE12: Accumulated input pulses read back as 32 bits over words three and four.
// RULE13: Source keeps input at most 10 kHz single phase, 2 kHz two phase.
// RULE14: Program should raise sample count with input speed for better accuracy.
// RULE15: Output ratio in percent, clamped to 1..10000.
// RULE16: New ratio takes effect only at the next instruction execution.
// RULE17: Output speed reads back signed 32 bits, high/low words, 1 Hz, +-100 kHz.
// RULE18: Output frequency is speed times ratio truncated to whole hertz.
// RULE19: Sign of sampled speed carries into the output speed.
// RULE20: Direction output low for positive, high for negative output speed.
// RULE21: Speed sample is pulses over elapsed system clock time.
package scrpo_pkg;

  // Register word offsets
  localparam logic [3:0] REG_SAMPLE_N = 4'h0;
  localparam logic [3:0] REG_IN_SPEED = 4'h1;
  localparam logic [3:0] REG_ACC_LO = 4'h2;
  localparam logic [3:0] REG_ACC_HI = 4'h3;
  localparam logic [3:0] REG_RATIO = 4'h4;
  localparam logic [3:0] REG_OUT_SPD_LO = 4'h5;
  localparam logic [3:0] REG_OUT_SPD_HI = 4'h6;
  localparam logic [3:0] REG_CTRL = 4'h7;
  localparam logic [3:0] REG_EXEC = 4'h8;
  localparam logic [3:0] REG_OCNT0_LO = 4'h9;
  localparam logic [3:0] REG_OCNT0_HI = 4'ha;
  localparam logic [3:0] REG_OCNT1_LO = 4'hb;
  localparam logic [3:0] REG_OCNT1_HI = 4'hc;

  // Control word fields
  localparam int CTRL_SRC_LSB = 0;
  localparam int CTRL_EN_BIT = 2;
  localparam int CTRL_GPO_LSB = 4;
  localparam int STAT_RUN_BIT = 0;
  localparam int STAT_REFUSED_BIT = 1;

  // Reset values
  localparam logic [15:0] RST_SAMPLE_N = 16'h0001;
  localparam logic [15:0] RST_RATIO = 16'h0064;
  localparam logic [15:0] RST_CTRL = 16'h0000;

  // Limits
  localparam logic [15:0] N_MIN_1PH = 16'h0001;
  localparam logic [15:0] N_MIN_2PH = 16'h0002;
  localparam logic [15:0] N_MAX = 16'h0064;
  localparam logic [15:0] RATIO_MIN = 16'h0001;
  localparam logic [15:0] RATIO_MAX = 16'h2710;
  localparam logic [31:0] SPEED_MAX = 32'h0000_2710;
  localparam logic [31:0] OUT_MAX = 32'h0001_86a0;
  localparam logic [31:0] PERCENT = 32'h0000_0064;

  // Timing
  localparam logic [31:0] CLK_HZ = 32'h017d_7840;
  localparam int STALL_TIME_MS = 1000;
  localparam int STALL_CYCLES = (25000000 / 1000) * STALL_TIME_MS;

  // Source selection
  typedef enum logic [1:0] {
    SRC_A0 = 2'b00,
    SRC_QUAD0 = 2'b01,
    SRC_A1 = 2'b10,
    SRC_QUAD1 = 2'b11
  } scrpo_src_t;

  // Divider sequencer
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DIV_SPEED = 2'b01,
    ST_DIV_OUT = 2'b10
  } scrpo_state_t;

  // Settings applied at execution
  typedef struct packed {
    scrpo_src_t src;
    logic [15:0] sample_n;
    logic [15:0] ratio;
  } scrpo_cfg_t;

endpackage : scrpo_pkg

// >>> core/scrpo_top.sv
// Speed catch and ratio pulse output core
//
// Our own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps

module scrpo_top #(
  parameter int STALL_CYCLES = scrpo_pkg::STALL_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Claims by other functions
  input wire logic [1:0] input_pair_claimed,
  input wire logic [1:0] output_pair_claimed,
  // Counter inputs
  input wire logic counter_input_a0,
  input wire logic counter_input_b0,
  input wire logic counter_input_a1,
  input wire logic counter_input_b1,
  // Pulse and direction outputs
  output logic pulse_output_0,
  output logic direction_output_0,
  output logic pulse_output_1,
  output logic direction_output_1
);

  ////////////////////////////////////////////////////////////////////////////
  // Software registers
  logic [15:0] sample_pulse_count;
  logic [15:0] output_ratio_percent;
  logic [15:0] ctrl;
  logic running;
  logic refused;
  scrpo_pkg::scrpo_cfg_t act;
  logic [31:0] out_cnt_run;
  logic [31:0] out_count_0;
  logic [31:0] out_count_1;

  // Measurement state
  logic [1:0] prev_ab;
  logic [15:0] pcnt;
  logic signed [15:0] net;
  logic [31:0] cyc;
  logic signed [31:0] accumulated_input_pulses;

  // Speed and output state
  scrpo_pkg::scrpo_state_t state;
  logic [64:0] rq;
  logic [31:0] divisor;
  logic [5:0] step;
  logic neg;
  logic signed [15:0] sampled_input_speed;
  logic [31:0] out_freq;
  logic signed [31:0] output_speed_value;
  logic [31:0] phase;
  logic pulse;

  ////////////////////////////////////////////////////////////////////////////
  // Register decode
  wire exec_req = reg_wr && (reg_addr == scrpo_pkg::REG_EXEC);
  wire [1:0] new_src = ctrl[scrpo_pkg::CTRL_SRC_LSB +: 2];
  wire new_en = ctrl[scrpo_pkg::CTRL_EN_BIT];
  wire new_quad = new_src[0];
  wire new_pair = new_src[1];
  wire claim_hit = input_pair_claimed[new_pair] || output_pair_claimed[new_pair]; // [RULE5]
  wire start_ok = exec_req && new_en && !claim_hit;
  wire start_bad = exec_req && new_en && claim_hit && !running;
  wire stop_req = exec_req && !new_en;
  wire restart = start_ok && (!running || (act.src != scrpo_pkg::scrpo_src_t'(new_src)));

  // Clamped settings
  wire [15:0] n_min = new_quad ? scrpo_pkg::N_MIN_2PH : scrpo_pkg::N_MIN_1PH;
  wire [15:0] n_clamped = (sample_pulse_count < n_min) ? n_min :
                          (sample_pulse_count > scrpo_pkg::N_MAX) ? scrpo_pkg::N_MAX :
                          sample_pulse_count; // [RULE9]
  wire [15:0] ratio_clamped = (output_ratio_percent < scrpo_pkg::RATIO_MIN) ?
                              scrpo_pkg::RATIO_MIN :
                              (output_ratio_percent > scrpo_pkg::RATIO_MAX) ?
                              scrpo_pkg::RATIO_MAX : output_ratio_percent; // [RULE15]

  // Register writes
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      sample_pulse_count <= scrpo_pkg::RST_SAMPLE_N;
      output_ratio_percent <= scrpo_pkg::RST_RATIO;
      ctrl <= scrpo_pkg::RST_CTRL;
    end
    else if (reg_wr)
    begin
      if (reg_addr == scrpo_pkg::REG_SAMPLE_N)
        sample_pulse_count <= reg_wdata; // Held until execution [RULE10]
      if (reg_addr == scrpo_pkg::REG_RATIO)
        output_ratio_percent <= reg_wdata; // Held until execution [RULE16]
      if (reg_addr == scrpo_pkg::REG_CTRL)
        ctrl <= reg_wdata;
    end
  end

  // Execution: apply, start, stop, refuse
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      running <= 1'b0;
      refused <= 1'b0;
      act <= '{src: scrpo_pkg::SRC_A0, sample_n: scrpo_pkg::RST_SAMPLE_N,
               ratio: scrpo_pkg::RST_RATIO};
    end
    else if (exec_req)
    begin
      refused <= start_bad; // [RULE5]
      if (start_ok)
      begin
        running <= 1'b1;
        act.src <= scrpo_pkg::scrpo_src_t'(new_src);
        act.sample_n <= n_clamped; // [RULE8] [RULE10]
        act.ratio <= ratio_clamped; // [RULE16]
      end
      else if (stop_req)
        running <= 1'b0;
    end
  end

  // Pulse count snapshots on execution
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      out_count_0 <= 32'h0000_0000;
      out_count_1 <= 32'h0000_0000;
    end
    else if (exec_req && running)
    begin
      if (!act.src[1])
        out_count_0 <= out_cnt_run; // [RULE7]
      else
        out_count_1 <= out_cnt_run; // [RULE7]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input decode
  wire act_quad = act.src[0];
  wire [1:0] cur_ab = act.src[1] ? {counter_input_a1, counter_input_b1} :
                                   {counter_input_a0, counter_input_b0};
  wire single_ev = cur_ab[1] && !prev_ab[1]; // [RULE1] [RULE3]
  wire quad_ev = (cur_ab[1] ^ prev_ab[1]) ^ (cur_ab[0] ^ prev_ab[0]); // [RULE6]
  wire quad_up = !(prev_ab[1] ^ cur_ab[0]); // [RULE2] [RULE4]
  wire in_ev = running && !restart && (act_quad ? quad_ev : single_ev);
  wire in_up = act_quad ? quad_up : 1'b1;
  wire signed [15:0] net_next = in_up ? net + 16'sh0001 : net - 16'sh0001;
  wire [15:0] pcnt_next = pcnt + 16'h0001;
  wire sample_go = in_ev && (pcnt_next >= act.sample_n); // [RULE8]
  wire stall_hit = running && (cyc >= 32'(STALL_CYCLES));

  // Previous input levels
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      prev_ab <= 2'b00;
    else
      prev_ab <= cur_ab;
  end

  // Pulse counting and sample timing
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      pcnt <= 16'h0000;
      net <= 16'sh0000;
      cyc <= 32'h0000_0000;
      accumulated_input_pulses <= 32'sh0000_0000;
    end
    else if (restart || !running || sample_go || stall_hit)
    begin
      pcnt <= 16'h0000;
      net <= 16'sh0000;
      cyc <= 32'h0000_0001; // [RULE21]
      if (restart)
        accumulated_input_pulses <= 32'sh0000_0000;
      else if (sample_go)
        accumulated_input_pulses <= in_up ? accumulated_input_pulses + 32'sh0000_0001 :
                                            accumulated_input_pulses - 32'sh0000_0001;
    end
    else
    begin
      cyc <= cyc + 32'h0000_0001; // [RULE21]
      if (in_ev)
      begin
        pcnt <= pcnt_next;
        net <= net_next;
        accumulated_input_pulses <= in_up ? accumulated_input_pulses + 32'sh0000_0001 :
                                            accumulated_input_pulses - 32'sh0000_0001; // [RULE12]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared divider
  wire [64:0] rq_sh = {rq[63:0], 1'b0};
  wire rq_fit = rq_sh[64:32] >= {1'b0, divisor};
  wire [64:0] rq_step = rq_fit ? {rq_sh[64:32] - {1'b0, divisor}, rq_sh[31:1], 1'b1} : rq_sh;
  wire [31:0] quot = rq_step[31:0];
  wire [31:0] spd_sat = (quot > scrpo_pkg::SPEED_MAX) ? scrpo_pkg::SPEED_MAX : quot; // [RULE11]
  wire [31:0] spd_mag = sampled_input_speed[15] ? 32'(-sampled_input_speed) :
                                                  32'(sampled_input_speed);
  wire [31:0] prod = spd_mag * {16'h0000, act.ratio}; // [RULE18]
  wire [31:0] frq_sat = (quot > scrpo_pkg::OUT_MAX) ? scrpo_pkg::OUT_MAX : quot; // [RULE17]
  wire [31:0] dividend_spd = 32'(act.sample_n) * scrpo_pkg::CLK_HZ; // [RULE21]
  wire div_done = (step == 6'h1f);

  // Speed, then output frequency
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      state <= scrpo_pkg::ST_IDLE;
      rq <= 65'h0;
      divisor <= 32'h0000_0001;
      step <= 6'h00;
      neg <= 1'b0;
      sampled_input_speed <= 16'sh0000;
      out_freq <= 32'h0000_0000;
      output_speed_value <= 32'sh0000_0000;
    end
    else if (restart || !running || stall_hit)
    begin
      state <= scrpo_pkg::ST_IDLE;
      sampled_input_speed <= 16'sh0000;
      out_freq <= 32'h0000_0000;
      output_speed_value <= 32'sh0000_0000;
    end
    else
    begin
      case (state)
        scrpo_pkg::ST_IDLE:
        begin
          step <= 6'h00;
          if (sample_go)
          begin
            neg <= net_next[15]; // [RULE19]
            rq <= {33'h0, dividend_spd};
            divisor <= cyc;
            state <= scrpo_pkg::ST_DIV_SPEED;
          end
        end
        scrpo_pkg::ST_DIV_SPEED:
        begin
          rq <= rq_step;
          step <= div_done ? 6'h00 : step + 6'h01; // Output division loads at step zero
          if (div_done)
          begin
            sampled_input_speed <= neg ? -16'(spd_sat) : 16'(spd_sat); // [RULE11] [RULE19]
            state <= scrpo_pkg::ST_DIV_OUT;
          end
        end
        scrpo_pkg::ST_DIV_OUT:
        begin
          if (step == 6'h00)
          begin
            rq <= {33'h0, prod};
            divisor <= scrpo_pkg::PERCENT;
            step <= 6'h20;
          end
          else
          begin
            rq <= rq_step;
            step <= (step == 6'h3f) ? 6'h00 : step + 6'h01;
            if (step == 6'h3f)
            begin
              out_freq <= frq_sat; // Truncated to whole hertz [RULE18]
              output_speed_value <= neg ? -$signed(frq_sat) : $signed(frq_sat); // [RULE19]
              state <= scrpo_pkg::ST_IDLE;
            end
          end
        end
        default:
          state <= scrpo_pkg::ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pulse generation
  wire [31:0] phase_add = phase + {out_freq[30:0], 1'b0};
  wire phase_wrap = phase_add >= scrpo_pkg::CLK_HZ;

  // Half-period toggle; zero emits nothing
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      phase <= 32'h0000_0000;
      pulse <= 1'b0;
      out_cnt_run <= 32'h0000_0000;
    end
    else if (restart || !running)
    begin
      phase <= 32'h0000_0000;
      pulse <= 1'b0;
      if (restart)
        out_cnt_run <= 32'h0000_0000;
    end
    else if (out_freq != 32'h0000_0000) // [RULE18]
    begin
      phase <= phase_wrap ? phase_add - scrpo_pkg::CLK_HZ : phase_add;
      if (phase_wrap)
      begin
        pulse <= !pulse;
        if (!pulse)
          out_cnt_run <= out_cnt_run + 32'h0000_0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin routing
  wire [3:0] gpo = ctrl[scrpo_pkg::CTRL_GPO_LSB +: 4];
  wire use0 = running && !act.src[1];
  wire use1 = running && act.src[1];
  wire dir_lvl = output_speed_value[31]; // High for reverse [RULE20]

  // Registered pin drive
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      pulse_output_0 <= 1'b0;
      direction_output_0 <= 1'b0;
      pulse_output_1 <= 1'b0;
      direction_output_1 <= 1'b0;
    end
    else
    begin
      pulse_output_0 <= use0 ? pulse : gpo[0]; // [RULE1] [RULE2]
      direction_output_0 <= (use0 && act_quad) ? dir_lvl : gpo[1]; // [RULE1] [RULE2] [RULE20]
      pulse_output_1 <= use1 ? pulse : gpo[2]; // [RULE3] [RULE4]
      direction_output_1 <= (use1 && act_quad) ? dir_lvl : gpo[3]; // [RULE3] [RULE4] [RULE20]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux
  wire [15:0] status = {14'h0000, refused, running};
  logic [15:0] rd_mux;
  always_comb
  begin
    case (reg_addr)
      scrpo_pkg::REG_SAMPLE_N: rd_mux = sample_pulse_count;
      scrpo_pkg::REG_IN_SPEED: rd_mux = sampled_input_speed; // [RULE11]
      scrpo_pkg::REG_ACC_LO: rd_mux = accumulated_input_pulses[15:0]; // [RULE12]
      scrpo_pkg::REG_ACC_HI: rd_mux = accumulated_input_pulses[31:16]; // [RULE12]
      scrpo_pkg::REG_RATIO: rd_mux = output_ratio_percent;
      scrpo_pkg::REG_OUT_SPD_LO: rd_mux = output_speed_value[15:0]; // [RULE17]
      scrpo_pkg::REG_OUT_SPD_HI: rd_mux = output_speed_value[31:16]; // [RULE17]
      scrpo_pkg::REG_CTRL: rd_mux = ctrl;
      scrpo_pkg::REG_EXEC: rd_mux = status;
      scrpo_pkg::REG_OCNT0_LO: rd_mux = out_count_0[15:0];
      scrpo_pkg::REG_OCNT0_HI: rd_mux = out_count_0[31:16];
      scrpo_pkg::REG_OCNT1_LO: rd_mux = out_count_1[15:0];
      scrpo_pkg::REG_OCNT1_HI: rd_mux = out_count_1[31:16];
      default: rd_mux = 16'h0000;
    endcase
  end

  // Read data for one cycle
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      reg_rdata <= 16'h0000;
    else
      reg_rdata <= reg_rd ? rd_mux : 16'h0000;
  end

endmodule : scrpo_top

// >>> testbench/scrpo_checker_assertions.sv
// Port checks for the speed follow core
`timescale 1ns/1ps

module scrpo_checker #(
  parameter int STALL_CYCLES = 2000
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  // Claims
  input wire logic [1:0] input_pair_claimed,
  input wire logic [1:0] output_pair_claimed,
  // Outputs
  input wire logic pulse_output_0,
  input wire logic direction_output_0,
  input wire logic pulse_output_1,
  input wire logic direction_output_1
);
  ////////////////////////////////////////////////////////////////////////////////
  // Run state shadow
  logic [15:0] ctrl_w;
  logic [1:0] src_m;
  logic running_m;
  logic refused_m;
  wire exec_w = reg_wr && reg_addr == scrpo_pkg::REG_EXEC;
  wire claim_w = input_pair_claimed[ctrl_w[1]] | output_pair_claimed[ctrl_w[1]];
  wire en_w = ctrl_w[scrpo_pkg::CTRL_EN_BIT];
  wire pair0_run = running_m && !src_m[1];
  wire pair1_run = running_m && src_m[1];

  // Track execution
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      ctrl_w <= 16'h0000;
      src_m <= 2'h0;
      running_m <= 1'b0;
      refused_m <= 1'b0;
    end
    else
    begin
      if (reg_wr && reg_addr == scrpo_pkg::REG_CTRL)
        ctrl_w <= reg_wdata;
      if (exec_w)
      begin
        refused_m <= en_w && claim_w && !running_m;
        if (!en_w)
          running_m <= 1'b0;
        else if (!claim_w)
        begin
          running_m <= 1'b1;
          src_m <= ctrl_w[1:0];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  rdata_idle_a:
    assert property (!reg_rd |=> reg_rdata == 16'h0000)
    else $error("Stray read data");
  unmapped_zero_a:
    assert property (reg_rd && reg_addr > scrpo_pkg::REG_OCNT1_HI |=> reg_rdata == 16'h0000)
    else $error("Unmapped read");
  status_match_a:
    assert property (reg_rd && reg_addr == scrpo_pkg::REG_EXEC
      |=> reg_rdata[1:0] == {refused_m, running_m})
    else $error("Bad status");
  dir0_ordinary_a:
    assert property (running_m && src_m == scrpo_pkg::SRC_A0 && $stable(ctrl_w)
      && $stable(src_m) |=> direction_output_0 == $past(ctrl_w[5]))
    else $error("Output 0 dir not ordinary");
  dir1_ordinary_a:
    assert property (running_m && src_m == scrpo_pkg::SRC_A1 && $stable(ctrl_w)
      && $stable(src_m) |=> direction_output_1 == $past(ctrl_w[7]))
    else $error("Output 1 dir not ordinary");
  pulse0_rate_a:
    assert property ($rose(pulse_output_0) && pair0_run |=> $stable(pulse_output_0) [*8])
    else $error("Pulse 0 too fast");
  pulse1_rate_a:
    assert property ($rose(pulse_output_1) && pair1_run |=> $stable(pulse_output_1) [*8])
    else $error("Pulse 1 too fast");
  dir0_steady_a:
    assert property ($changed(direction_output_0) && running_m
      && src_m == scrpo_pkg::SRC_QUAD0 |=> $stable(direction_output_0) [*8])
    else $error("Dir 0 chatters");

  // Main scenarios
  cover property (exec_w && en_w && claim_w && !running_m);
  cover property ($rose(pulse_output_1) && pair1_run);
  cover property (running_m && src_m == scrpo_pkg::SRC_QUAD0 && direction_output_0);
endmodule : scrpo_checker

bind scrpo_top scrpo_checker #(.STALL_CYCLES(STALL_CYCLES)) i_scrpo_checker (
  .mclk(mclk),
  .rst(rst),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_rdata(reg_rdata),
  .input_pair_claimed(input_pair_claimed),
  .output_pair_claimed(output_pair_claimed),
  .pulse_output_0(pulse_output_0),
  .direction_output_0(direction_output_0),
  .pulse_output_1(pulse_output_1),
  .direction_output_1(direction_output_1)
);

// >>> testbench/scrpo_encoder_model.sv
// Encoder pulse source
`timescale 1ns/1ps

module scrpo_encoder_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Motion command
  input wire logic run,
  input wire logic quad,
  input wire logic reverse,
  input wire logic [15:0] step,
  // Encoder lines
  output logic phase_a,
  output logic phase_b,
  output logic [31:0] edge_count
);
  logic [15:0] timer;
  logic [1:0] phase;
  logic run_q;
  // Source rate ceiling
  wire [15:0] min_step = quad ? 16'h0c35 : 16'h04e2;
  wire [15:0] use_step = step < min_step ? min_step : step;
  wire [1:0] next_phase = reverse ? phase - 2'h1 : phase + 2'h1;
  wire tick = run && timer >= use_step - 16'h0001;
  wire counted = quad || next_phase[0];

  // Gray code, a leads b forward
  assign phase_a = quad ? phase[1] ^ phase[0] : phase[0];
  assign phase_b = quad ? phase[1] : 1'b0;

  // Step timer and edge tally
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      timer <= 16'h0000;
      phase <= 2'h0;
      run_q <= 1'b0;
      edge_count <= 32'h0000_0000;
    end
    else
    begin
      run_q <= run;
      timer <= (!run || tick) ? 16'h0000 : timer + 16'h0001;
      if (tick)
        phase <= next_phase;
      if (run && !run_q)
        edge_count <= 32'h0000_0000;
      else if (tick && counted)
        edge_count <= edge_count + 32'h0000_0001;
    end
  end
endmodule : scrpo_encoder_model

// >>> testbench/scrpo_top_test.sv
// Bench for the speed follow core
`timescale 1ns/1ps

module scrpo_top_test;
  ////////////////////////////////////////////////////////////////////////////////
  // Signals
  localparam logic [15:0] STEP_S = 16'h05dc;
  localparam logic [15:0] STEP_Q = 16'h0c35;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0, reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic [1:0] input_pair_claimed = 2'h0, output_pair_claimed = 2'h0;
  logic run = 1'b0, quad = 1'b0, reverse = 1'b0, pair = 1'b0;
  logic phase_a, phase_b;
  logic [31:0] edge_count;
  logic pulse_output_0, direction_output_0, pulse_output_1, direction_output_1;
  logic [31:0] v, rspd;
  int n_mismatch = 0;
  int tests_run = 0;
  int seed = 28;

  // Clock
  always #20 mclk = ~mclk;

  ////////////////////////////////////////////////////////////////////////////////
  // Design and source
  scrpo_top #(
    .STALL_CYCLES(20000)
  ) i_scrpo_top (
    .mclk(mclk),
    .rst(rst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .input_pair_claimed(input_pair_claimed),
    .output_pair_claimed(output_pair_claimed),
    .counter_input_a0(pair ? 1'b0 : phase_a),
    .counter_input_b0(pair ? 1'b0 : phase_b),
    .counter_input_a1(pair ? phase_a : 1'b0),
    .counter_input_b1(pair ? phase_b : 1'b0),
    .pulse_output_0(pulse_output_0),
    .direction_output_0(direction_output_0),
    .pulse_output_1(pulse_output_1),
    .direction_output_1(direction_output_1)
  );

  scrpo_encoder_model i_scrpo_encoder_model (
    .mclk(mclk),
    .rst(rst),
    .run(run),
    .quad(quad),
    .reverse(reverse),
    .step(quad ? STEP_Q : STEP_S),
    .phase_a(phase_a),
    .phase_b(phase_b),
    .edge_count(edge_count)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] expected);
    tests_run++;
    if (seen !== expected)
    begin
      n_mismatch++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, expected);
    end
  endtask : check

  task automatic give_verdict();
    if (n_mismatch == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(posedge mclk);
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = {16'h0000, reg_rdata};
    @(posedge mclk);
  endtask : rd

  task automatic rd32(input logic [3:0] a, output logic [31:0] d);
    logic [31:0] lo, hi;
    rd(a, lo);
    rd(a + 4'h1, hi);
    d = {hi[15:0], lo[15:0]};
  endtask : rd32

  // Expected speed
  function automatic logic [31:0] exp_speed(input logic q, input logic rev);
    logic [31:0] s;
    s = scrpo_pkg::CLK_HZ / (q ? 32'(STEP_Q) : 32'(STEP_S) * 2);
    return rev ? -s : s;
  endfunction : exp_speed

  function automatic logic [31:0] exp_out(input logic [31:0] spd, input logic [15:0] ratio);
    logic [15:0] r;
    logic [63:0] p;
    r = ratio < scrpo_pkg::RATIO_MIN ? scrpo_pkg::RATIO_MIN : ratio;
    r = r > scrpo_pkg::RATIO_MAX ? scrpo_pkg::RATIO_MAX : r;
    p = {32'h0000_0000, (spd[31] ? -spd : spd)} * r / scrpo_pkg::PERCENT;
    p = p > scrpo_pkg::OUT_MAX ? 64'(scrpo_pkg::OUT_MAX) : p;
    return spd[31] ? -p[31:0] : p[31:0];
  endfunction : exp_out

  // One source run forward
  task automatic follow(input logic [1:0] s, input logic [15:0] ratio);
    logic [31:0] spd;
    logic [31:0] cnt;
    logic [3:0] gpo;
    gpo = 4'($random(seed));
    spd = exp_speed(s[0], 1'b0);
    quad <= s[0];
    pair <= s[1];
    wr(scrpo_pkg::REG_SAMPLE_N, 16'($unsigned($random(seed)) % 3));
    wr(scrpo_pkg::REG_RATIO, ratio);
    wr(scrpo_pkg::REG_CTRL, {8'h00, gpo, 2'h1, s});
    wr(scrpo_pkg::REG_EXEC, 16'h0000);
    run <= 1'b1;
    repeat (13000) @(posedge mclk);
    rd(scrpo_pkg::REG_IN_SPEED, v);
    check(v, {16'h0000, spd[15:0]});
    rd32(scrpo_pkg::REG_OUT_SPD_LO, v);
    check(v, exp_out(spd, ratio));
    check(32'(s[1] ? direction_output_1 : direction_output_0),
      32'(s[0] ? 1'b0 : gpo[{s[1], 1'b1}]));
    if (s == 2'h3)
    begin
      rd32(scrpo_pkg::REG_OCNT1_LO, cnt);
      repeat (300) @(posedge mclk);
      rd32(scrpo_pkg::REG_OCNT1_LO, v);
      check(v, cnt);
      wr(scrpo_pkg::REG_EXEC, 16'h0000);
      rd32(scrpo_pkg::REG_OCNT1_LO, v);
      check(32'(v != cnt), 32'h0000_0001);
    end
    run <= 1'b0;
    repeat (4) @(posedge mclk);
    rd32(scrpo_pkg::REG_ACC_LO, v);
    check(v, edge_count);
  endtask : follow

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    rd(scrpo_pkg::REG_SAMPLE_N, v);
    check(v, 32'(scrpo_pkg::RST_SAMPLE_N));
    rd(scrpo_pkg::REG_RATIO, v);
    check(v, 32'(scrpo_pkg::RST_RATIO));
    wr(scrpo_pkg::REG_IN_SPEED, 16'h1234);
    rd(scrpo_pkg::REG_IN_SPEED, v);
    check(v, 32'h0000_0000);
    rd(4'hf, v);
    check(v, 32'h0000_0000);
    // Claims on the chosen pair refuse start; a claim on the other pair does not
    wr(scrpo_pkg::REG_CTRL, 16'h0004);
    for (int k = 0; k < 3; k++)
    begin
      input_pair_claimed <= (k == 0) ? 2'h1 : 2'h0;
      output_pair_claimed <= (k == 1) ? 2'h1 : (k == 2) ? 2'h2 : 2'h0;
      wr(scrpo_pkg::REG_EXEC, 16'h0000);
      rd(scrpo_pkg::REG_EXEC, v);
      check(v, (k == 2) ? 32'h0000_0001 : 32'h0000_0002);
    end
    output_pair_claimed <= 2'h0;
    wr(scrpo_pkg::REG_CTRL, 16'h0000);
    wr(scrpo_pkg::REG_EXEC, 16'h0000);
    rd(scrpo_pkg::REG_EXEC, v);
    check(v, 32'h0000_0000);
    // Every source
    follow(2'h0, 16'h0007);
    follow(2'h2, 16'h0001 + 16'($unsigned($random(seed)) % 10000));
    follow(2'h3, 16'h4e20);
    follow(2'h1, 16'h0000);
    // Reverse, ratio applied at next execution
    rspd = exp_speed(1'b1, 1'b1);
    reverse <= 1'b1;
    run <= 1'b1;
    wr(scrpo_pkg::REG_RATIO, 16'h0032);
    repeat (13000) @(posedge mclk);
    rd(scrpo_pkg::REG_IN_SPEED, v);
    check(v, {16'h0000, rspd[15:0]});
    rd32(scrpo_pkg::REG_OUT_SPD_LO, v);
    check(v, exp_out(rspd, 16'h0001));
    check(32'(direction_output_0), 32'h0000_0001);
    wr(scrpo_pkg::REG_EXEC, 16'h0000);
    repeat (13000) @(posedge mclk);
    rd32(scrpo_pkg::REG_OUT_SPD_LO, v);
    check(v, exp_out(rspd, 16'h0032));
    give_verdict();
  end

  // Watchdog
  initial
  begin
    repeat (95000) @(posedge mclk);
    n_mismatch++;
    give_verdict();
  end
endmodule : scrpo_top_test
